// ===== common/cpu_instr_pkg.sv
// types shared by the instruction decoder
package cpu_instr_pkg;

    typedef enum logic [1:0] {
        q_decode,
        q_read,
        q_process,
        q_write
    } phase_t;

    typedef enum logic [3:0] {
        op_none,
        op_long_subroutine_jump,
        op_clear_file_register,
        op_watchdog_clear,
        op_complement_file,
        op_skip_if_equal,
        op_skip_if_greater,
        op_skip_if_less,
        op_decimal_adjust,
        op_decrement_file
    } op_t;

endpackage : cpu_instr_pkg

// ===== common/cpu_instr_regs.svh
// opcode patterns, field positions and reset values of the decoder
`ifndef CPU_INSTR_REGS_SVH
`define CPU_INSTR_REGS_SVH

`define CALL_OPC_MSB      15
`define CALL_OPC_LSB      13
`define CALL_OPC          3'h7
`define CALL_LIT_MSB      12
`define FILE_ADDR_MSB     7
`define SEL_BIT           8
`define OPC7_MSB          15
`define OPC7_LSB          9
`define OPC8_LSB          8
`define CLEAR_FILE_REGISTER_OPC          7'h14
`define COMPLEMENT_FILE_OPC          7'h09
`define DAW_OPC           7'h17
`define DECREMENT_FILE_OPC          7'h03
`define SKIP_IF_LESS_OPC        8'h30
`define SKIP_IF_EQUAL_OPC        8'h31
`define SKIP_IF_GREATER_OPC        8'h32
`define WDT_CLEAR_WORD    16'h0004
`define NOP_WORD          16'h0000
`define PC_PAGE_MSB       15
`define PC_PAGE_LSB       13
`define PC_UPPER_LSB      8
`define BCD_DIGIT_MAX     4'h9
`define BCD_ADJUST        4'h6
`define PC_RESET          16'h0000
`define BYTE_RESET        8'h00
`define FLAG_N_RESET      1'b1

`endif

// ===== hw/cpu_instr_call_to_decrement_file.sv
// decode and execute of the call-to-decrement instruction group
`timescale 1ns/1ps
`include "cpu_instr_regs.svh"

// Function
// - call recognised by top three ones
// - call pushes pc plus one onto stack
// - call loads literal into pc low bits
// - call copies upper pc, then nop cycle
// - clear location, and working register if s=0
// - fixed word decodes as watchdog clear
// - watchdog clear resets counter, sets flags
// - complement decoded from its opcode
// - complement result to d destination, zero flag
// - equal compare decoded, flags untouched
// - equal skips next instruction with nop
// - greater compare decoded, flags untouched
// - greater skips next, else one cycle
// - less compare decoded, flags untouched
// - less skips next instruction with nop
// - decimal adjust decoded, carry only
// - add six to nibbles over nine
// - adjust result to location, maybe working
// - decrement decoded from its opcode
// - decrement to destination, four flags
// - skipped instruction becomes full nop cycle
module cpu_instr_call_to_decrement_file
    import cpu_instr_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic [15:0] instr_word,
    input  wire logic [7:0]  file_rd_data,
    input  wire logic        wdt_timeout,
    input  wire logic        sleep_entry,
    output logic      [15:0] fetch_addr,
    output logic      [7:0]  file_addr,
    output logic             file_wr_en,
    output logic      [7:0]  file_wr_data,
    output logic             stack_push,
    output logic      [15:0] stack_top,
    output logic      [7:0]  upper_pc_latch,
    output logic      [7:0]  working_register,
    output logic             watchdog_clear,
    output logic             carry_flag,
    output logic             digit_carry,
    output logic             zero_flag,
    output logic             overflow_flag,
    output logic             timeout_flag_n,
    output logic             powerdown_flag_n,
    output logic      [1:0]  quarter
);

    phase_t      phase;
    logic [15:0] ir;
    logic        nop_pending;
    logic        exec_nop;
    logic [7:0]  operand;

    wire         q1 = (phase == q_decode);
    wire         q2 = (phase == q_read);
    wire         q3 = (phase == q_process);
    wire         q4 = (phase == q_write);

    phase_t      next_phase;
    always_comb begin
        unique case (phase)
            q_decode:  next_phase = q_read;
            q_read:    next_phase = q_process;
            q_process: next_phase = q_write;
            q_write:   next_phase = q_decode;
        endcase
    end

    // decode
    wire [6:0] opc7 = ir[`OPC7_MSB:`OPC7_LSB];
    wire [7:0] opc8 = ir[`OPC7_MSB:`OPC8_LSB];
    wire       sel  = ir[`SEL_BIT];
    wire [7:0] faddr = ir[`FILE_ADDR_MSB:0];
    wire [12:0] lit = ir[`CALL_LIT_MSB:0];

    wire dec_call = (ir[`CALL_OPC_MSB:`CALL_OPC_LSB] == `CALL_OPC);
    wire dec_clear_file_register = (opc7 == `CLEAR_FILE_REGISTER_OPC);
    wire dec_wdt  = (ir == `WDT_CLEAR_WORD);
    wire dec_complement_file = (opc7 == `COMPLEMENT_FILE_OPC);
    wire dec_seq  = (opc8 == `SKIP_IF_EQUAL_OPC);
    wire dec_sgt  = (opc8 == `SKIP_IF_GREATER_OPC);
    wire dec_slt  = (opc8 == `SKIP_IF_LESS_OPC);
    wire dec_daw  = (opc7 == `DAW_OPC);
    wire dec_decrement_file = (opc7 == `DECREMENT_FILE_OPC);

    // other opcodes belong to other decoders and act as nop here
    op_t op;
    assign op = exec_nop ? op_none :
                dec_call ? op_long_subroutine_jump :
                dec_clear_file_register ? op_clear_file_register :
                dec_wdt  ? op_watchdog_clear :
                dec_complement_file ? op_complement_file :
                dec_seq  ? op_skip_if_equal :
                dec_sgt  ? op_skip_if_greater :
                dec_slt  ? op_skip_if_less :
                dec_daw  ? op_decimal_adjust :
                dec_decrement_file ? op_decrement_file : op_none;

    wire is_call = (op == op_long_subroutine_jump);
    wire is_clear_file_register = (op == op_clear_file_register);
    wire is_wdt  = (op == op_watchdog_clear);
    wire is_complement_file = (op == op_complement_file);
    wire is_seq  = (op == op_skip_if_equal);
    wire is_sgt  = (op == op_skip_if_greater);
    wire is_slt  = (op == op_skip_if_less);
    wire is_daw  = (op == op_decimal_adjust);
    wire is_decrement_file = (op == op_decrement_file);
    wire reads_f = is_clear_file_register | is_complement_file | is_seq | is_sgt | is_slt
                 | is_daw | is_decrement_file;

    // execute datapath
    wire [15:0] pc_plus1 = fetch_addr + 16'h0001;
    wire [15:0] call_pc  = {fetch_addr[`PC_PAGE_MSB:`PC_PAGE_LSB], lit};
    wire        cmp_eq   = (operand == working_register);
    wire        cmp_gt   = (operand >  working_register);
    wire        cmp_lt   = (operand <  working_register);
    wire        do_skip  = (is_seq & cmp_eq) | (is_sgt & cmp_gt)
                         | (is_slt & cmp_lt);

    wire [7:0] comp_res = ~operand;

    // subtracting one: carry means no borrow
    wire [7:0] dec_res  = operand - 8'h01;
    wire       dec_c    = (operand != `BYTE_RESET);
    wire       dec_dc   = (operand[3:0] != 4'h0);
    wire       dec_ov   = (operand == 8'h80);

    // nibbles are adjusted independently, no carry between them
    wire       lo_adj   = (working_register[3:0] > `BCD_DIGIT_MAX)
                        | digit_carry;
    wire       hi_adj   = (working_register[7:4] > `BCD_DIGIT_MAX)
                        | carry_flag;
    wire [4:0] lo_sum   = {1'b0, working_register[3:0]}
                        + {1'b0, (lo_adj ? `BCD_ADJUST : 4'h0)};
    wire [4:0] hi_sum   = {1'b0, working_register[7:4]}
                        + {1'b0, (hi_adj ? `BCD_ADJUST : 4'h0)};
    wire [7:0] daw_res  = {hi_sum[3:0], lo_sum[3:0]};
    wire       daw_c    = carry_flag | hi_sum[4];

    wire       wr_file  = is_clear_file_register | is_daw
                        | ((is_complement_file | is_decrement_file) & sel);
    wire       wr_work  = ((is_clear_file_register | is_daw) & ~sel)
                        | ((is_complement_file | is_decrement_file) & ~sel);
    wire [7:0] result   = is_clear_file_register ? `BYTE_RESET :
                          is_complement_file ? comp_res :
                          is_daw  ? daw_res  :
                          is_decrement_file ? dec_res  : `BYTE_RESET;

    // quarter sequencing and instruction latch
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            phase       <= q_decode;
            ir          <= `NOP_WORD;
            exec_nop    <= 1'b0;
            nop_pending <= 1'b0;
        end else begin
            phase <= next_phase;
            if (q1) begin
                ir          <= instr_word;
                exec_nop    <= nop_pending;
                nop_pending <= 1'b0;
            end
            if (q4) begin
                nop_pending <= is_call | do_skip;
            end
        end
    end

    assign quarter = phase;

    // program counter, stack push and upper latch
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            fetch_addr     <= `PC_RESET;
            stack_push     <= 1'b0;
            stack_top      <= `PC_RESET;
            upper_pc_latch <= `BYTE_RESET;
        end else begin
            stack_push <= q2 & is_call;
            if (q2 && is_call) begin
                stack_top <= pc_plus1;
            end
            if (q4) begin
                fetch_addr <= is_call ? call_pc : pc_plus1;
            end
            if (q4 && is_call) begin
                upper_pc_latch <= call_pc[15:`PC_UPPER_LSB];
            end
        end
    end

    // register file port
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            file_addr    <= `BYTE_RESET;
            operand      <= `BYTE_RESET;
            file_wr_en   <= 1'b0;
            file_wr_data <= `BYTE_RESET;
        end else begin
            if (q2 && reads_f) begin
                file_addr <= faddr;
            end
            if (q3) begin
                operand <= file_rd_data;
            end
            file_wr_en <= q4 & wr_file;
            if (q4) begin
                file_wr_data <= result;
            end
        end
    end

    // working register and arithmetic flags
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            working_register <= `BYTE_RESET;
            carry_flag       <= 1'b0;
            digit_carry      <= 1'b0;
            zero_flag        <= 1'b0;
            overflow_flag    <= 1'b0;
        end else if (q4) begin
            if (wr_work) begin
                working_register <= result;
            end
            if (is_complement_file) begin
                zero_flag <= (comp_res == `BYTE_RESET);
            end
            if (is_decrement_file) begin
                carry_flag    <= dec_c;
                digit_carry   <= dec_dc;
                overflow_flag <= dec_ov;
                zero_flag     <= (dec_res == `BYTE_RESET);
            end
            if (is_daw) begin
                carry_flag <= daw_c;
            end
        end
    end

    // watchdog clear; a clear in the same cycle as an event wins
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            watchdog_clear   <= 1'b0;
            timeout_flag_n   <= `FLAG_N_RESET;
            powerdown_flag_n <= `FLAG_N_RESET;
        end else begin
            watchdog_clear <= q4 & is_wdt;
            if (q4 && is_wdt) begin
                timeout_flag_n   <= 1'b1;
                powerdown_flag_n <= 1'b1;
            end else begin
                if (wdt_timeout) begin
                    timeout_flag_n <= 1'b0;
                end
                if (sleep_entry) begin
                    powerdown_flag_n <= 1'b0;
                end
            end
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    property p_call_pc;
        q4 && is_call |=> fetch_addr ==
            {$past(fetch_addr[15:13]), $past(ir[12:0])};
    endproperty
    a_call_pc: assert property (p_call_pc)
        else $error("call did not load page literal");

    property p_call_push;
        q2 && is_call |=> stack_push && stack_top == $past(fetch_addr) + 1;
    endproperty
    a_call_push: assert property (p_call_push)
        else $error("call did not push return address");

    property p_call_latch;
        q4 && is_call |=> upper_pc_latch == fetch_addr[15:8];
    endproperty
    a_call_latch: assert property (p_call_latch)
        else $error("upper pc latch not copied");

    property p_call_nop;
        q4 && is_call |=> ##3 (exec_nop && !reads_f) ##1 !file_wr_en;
    endproperty
    a_call_nop: assert property (p_call_nop)
        else $error("second call cycle not a nop");

    property p_clear_file_register;
        q4 && is_clear_file_register |=> file_wr_en && file_wr_data == 8'h00
            && ($past(sel) || working_register == 8'h00);
    endproperty
    a_clear_file_register: assert property (p_clear_file_register)
        else $error("clear did not zero destinations");

    property p_wdt;
        q4 && is_wdt |=> watchdog_clear && timeout_flag_n
            && powerdown_flag_n ##1 !watchdog_clear;
    endproperty
    a_wdt: assert property (p_wdt)
        else $error("watchdog clear misbehaved");

    property p_complement_file;
        q4 && is_complement_file && !sel |=> working_register == ~$past(operand)
            && zero_flag == ($past(operand) == 8'hFF);
    endproperty
    a_complement_file: assert property (p_complement_file)
        else $error("complement result wrong");

    property p_skip_eq;
        q4 && is_seq && operand == working_register |=> nop_pending
            ##1 exec_nop;
    endproperty
    a_skip_eq: assert property (p_skip_eq)
        else $error("equal compare did not skip");

    property p_skip_gt;
        q4 && is_sgt |=> nop_pending == ($past(operand) >
            $past(working_register));
    endproperty
    a_skip_gt: assert property (p_skip_gt)
        else $error("greater compare skip wrong");

    property p_skip_lt;
        q4 && is_slt |=> nop_pending == ($past(operand) <
            $past(working_register));
    endproperty
    a_skip_lt: assert property (p_skip_lt)
        else $error("less compare skip wrong");

    property p_cmp_flags;
        q4 && (is_seq || is_sgt || is_slt) |=> $stable(carry_flag)
            && $stable(zero_flag) && $stable(digit_carry)
            && $stable(overflow_flag);
    endproperty
    a_cmp_flags: assert property (p_cmp_flags)
        else $error("compare altered a flag");

    property p_daw;
        q4 && is_daw && !sel |=> working_register == $past(daw_res)
            && file_wr_en && file_wr_data == working_register;
    endproperty
    a_daw: assert property (p_daw)
        else $error("decimal adjust destinations wrong");

    property p_decrement_file;
        q4 && is_decrement_file |=> zero_flag == ($past(operand) == 8'h01)
            && carry_flag == ($past(operand) != 8'h00);
    endproperty
    a_decrement_file: assert property (p_decrement_file)
        else $error("decrement flags wrong");

    property p_nop_quiet;
        q2 && exec_nop |=> ##2 !file_wr_en && !stack_push
            && !watchdog_clear;
    endproperty
    a_nop_quiet: assert property (p_nop_quiet)
        else $error("skipped cycle performed an action");

endmodule : cpu_instr_call_to_decrement_file

// ===== tb/cpu_instr_call_to_decrement_file_bench.sv
// self-checking bench for the call-to-decrement decoder
`timescale 1ns/1ps
module cpu_instr_call_to_decrement_file_bench;
    import cpu_instr_pkg::*;
    typedef struct packed {
        logic [15:0] word;
        logic [7:0]  rd;
        logic [7:0]  w;
        logic        wr;
        logic [7:0]  wd;
        logic [3:0]  fl;
    } row_t;
    typedef struct packed {
        logic [15:0] word;
        logic [7:0]  rd;
        logic        taken;
    } skip_t;
    logic        core_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [15:0] instr_word = 16'h0000;
    logic [7:0]  file_rd_data = 8'h00;
    logic        wdt_timeout = 1'b0;
    logic        sleep_entry = 1'b0;
    logic [15:0] fetch_addr, stack_top;
    logic [7:0]  file_addr, file_wr_data, upper_pc_latch, working_register;
    logic        file_wr_en, stack_push, watchdog_clear;
    logic        carry_flag, digit_carry, zero_flag, overflow_flag;
    logic        timeout_flag_n, powerdown_flag_n;
    logic [1:0]  quarter;
    wire  [3:0]  flags = {overflow_flag, carry_flag, digit_carry, zero_flag};
    int          n_fail = 0;
    int          checked = 0;
    int          n_wdc = 0;
    int          wdc0;
    logic [15:0] exp_pc = 16'h0000;
    // flags column is {overflow, carry, digit carry, zero}, chained row to row
    row_t rows [16] = '{
        '{16'h1211, 8'h13, 8'hEC, 1'b0, 8'h00, 4'h0},
        '{16'h1322, 8'hFF, 8'hEC, 1'b1, 8'h00, 4'h1},
        '{16'h0733, 8'h01, 8'hEC, 1'b1, 8'h00, 4'h7},
        '{16'h0644, 8'h80, 8'h7F, 1'b0, 8'h00, 4'hC},
        '{16'h0655, 8'h00, 8'hFF, 1'b0, 8'h00, 4'h0},
        '{16'h2966, 8'h5A, 8'hFF, 1'b1, 8'h00, 4'h0},
        '{16'h2877, 8'h5A, 8'h00, 1'b1, 8'h00, 4'h0},
        '{16'h1288, 8'h5A, 8'hA5, 1'b0, 8'h00, 4'h0},
        '{16'h2E99, 8'h00, 8'h05, 1'b1, 8'h05, 4'h4},
        '{16'h12AA, 8'h31, 8'hCE, 1'b0, 8'h00, 4'h4},
        '{16'h2FBB, 8'h00, 8'hCE, 1'b1, 8'h24, 4'h4},
        '{16'h07CC, 8'h01, 8'hCE, 1'b1, 8'h00, 4'h7},
        '{16'h12DD, 8'hEE, 8'h11, 1'b0, 8'h00, 4'h6},
        '{16'h2EEE, 8'h00, 8'h77, 1'b1, 8'h77, 4'h6},
        '{16'h0005, 8'h00, 8'h77, 1'b0, 8'h00, 4'h6},
        '{16'h31F0, 8'h00, 8'h77, 1'b0, 8'h00, 4'h6}
    };
    // working register is 0x40 before each compare
    skip_t skips [6] = '{
        '{16'h3110, 8'h40, 1'b1}, '{16'h3111, 8'h41, 1'b0},
        '{16'h3212, 8'h41, 1'b1}, '{16'h3213, 8'h40, 1'b0},
        '{16'h3014, 8'h3F, 1'b1}, '{16'h3015, 8'h40, 1'b0}
    };

    cpu_instr_call_to_decrement_file dut (
        .core_clk         (core_clk),
        .rst_n            (rst_n),
        .instr_word       (instr_word),
        .file_rd_data     (file_rd_data),
        .wdt_timeout      (wdt_timeout),
        .sleep_entry      (sleep_entry),
        .fetch_addr       (fetch_addr),
        .file_addr        (file_addr),
        .file_wr_en       (file_wr_en),
        .file_wr_data     (file_wr_data),
        .stack_push       (stack_push),
        .stack_top        (stack_top),
        .upper_pc_latch   (upper_pc_latch),
        .working_register (working_register),
        .watchdog_clear   (watchdog_clear),
        .carry_flag       (carry_flag),
        .digit_carry      (digit_carry),
        .zero_flag        (zero_flag),
        .overflow_flag    (overflow_flag),
        .timeout_flag_n   (timeout_flag_n),
        .powerdown_flag_n (powerdown_flag_n),
        .quarter          (quarter)
    );

    always #20 core_clk = ~core_clk;

    always @(posedge core_clk) begin
        if (watchdog_clear === 1'b1) begin
            n_wdc <= n_wdc + 1;
        end
    end

    task automatic chk_val(input string name, input logic [15:0] exp,
                           input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask : chk_val

    task automatic chk_bit(input string name, input logic exp,
                           input logic got);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %s expected %b seen %b", name, exp, got);
        end
    endtask : chk_bit

    // one full instruction cycle; returns just after the edge ending q4
    task automatic step(input logic [15:0] word, input logic [7:0] rd);
        instr_word <= word;
        file_rd_data <= rd;
        repeat (4) @(posedge core_clk);
        #1;
    endtask : step

    task automatic check_reset();
        chk_val("fetch_addr", 16'h0000, fetch_addr);
        chk_val("working_register", 16'h0000, {8'h00, working_register});
        chk_val("flags", 16'h0000, {12'h000, flags});
        chk_val("quarter", 16'h0000, {14'h0, quarter});
        chk_bit("file_wr_en", 1'b0, file_wr_en);
        chk_bit("stack_push", 1'b0, stack_push);
        chk_bit("timeout_flag_n", 1'b1, timeout_flag_n);
        chk_bit("powerdown_flag_n", 1'b1, powerdown_flag_n);
    endtask : check_reset

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : print_verdict

    initial begin
        // covers the page walk of about 8200 instruction cycles
        repeat (50000) @(posedge core_clk);
        n_fail++;
        print_verdict();
    end

    initial begin
        repeat (12) @(posedge core_clk);
        #1;
        check_reset();
        $display("reset test done");
        @(posedge core_clk);
        rst_n <= 1'b1;
        foreach (rows[i]) begin
            step(rows[i].word, rows[i].rd);
            exp_pc++;
            chk_val("working_register", {8'h00, rows[i].w}, {8'h00, working_register});
            chk_val("flags", {12'h000, rows[i].fl}, {12'h000, flags});
            chk_bit("file_wr_en", rows[i].wr, file_wr_en);
            chk_val("fetch_addr", exp_pc, fetch_addr);
            if (rows[i].wr) begin
                chk_val("file_wr_data", {8'h00, rows[i].wd}, {8'h00, file_wr_data});
                chk_val("file_addr", {8'h00, rows[i].word[7:0]}, {8'h00, file_addr});
            end
        end
        chk_val("watchdog pulses", 16'h0000, 16'(n_wdc));
        $display("table test done");
        wdt_timeout <= 1'b1;
        sleep_entry <= 1'b1;
        step(16'h0000, 8'h00);
        exp_pc++;
        wdt_timeout <= 1'b0;
        sleep_entry <= 1'b0;
        chk_bit("timeout_flag_n", 1'b0, timeout_flag_n);
        chk_bit("powerdown_flag_n", 1'b0, powerdown_flag_n);
        wdc0 = n_wdc;
        step(16'h0004, 8'h00);
        exp_pc++;
        // the pulse is counted one edge later, so only its level is seen here
        chk_bit("watchdog_clear", 1'b1, watchdog_clear);
        chk_bit("timeout_flag_n", 1'b1, timeout_flag_n);
        chk_bit("powerdown_flag_n", 1'b1, powerdown_flag_n);
        chk_val("fetch_addr", exp_pc, fetch_addr);
        $display("watchdog test done");
        // the word behind a compare would load 0xFF if it ran
        foreach (skips[i]) begin
            step(16'h1201, 8'hBF);
            step(skips[i].word, skips[i].rd);
            chk_val("flags", 16'h0006, {12'h000, flags});
            chk_bit("file_wr_en", 1'b0, file_wr_en);
            step(16'h1202, 8'h00);
            exp_pc += 3;
            chk_val("working_register", skips[i].taken ? 16'h0040 : 16'h00FF, {8'h00, working_register});
            chk_val("fetch_addr", exp_pc, fetch_addr);
        end
        // no clear word since, so a stuck pulse would count more than one
        chk_val("watchdog pulses", 16'h0001, 16'(n_wdc - wdc0));
        $display("skip test done");
        // walk into the second page so the kept pc bits are nonzero
        while (exp_pc != 16'h2000) begin
            step(16'h0000, 8'h00);
            exp_pc++;
        end
        chk_val("fetch_addr", 16'h2000, fetch_addr);
        instr_word <= 16'hE123;
        file_rd_data <= 8'h00;
        repeat (2) @(posedge core_clk);
        #1;
        chk_val("quarter", 16'h0002, {14'h0, quarter});
        chk_bit("stack_push", 1'b1, stack_push);
        chk_val("stack_top", 16'h2001, stack_top);
        @(posedge core_clk);
        #1;
        chk_bit("stack_push", 1'b0, stack_push);
        @(posedge core_clk);
        #1;
        chk_val("fetch_addr", 16'h2123, fetch_addr);
        chk_val("upper_pc_latch", 16'h0021, {8'h00, upper_pc_latch});
        step(16'h0601, 8'h05);
        chk_val("working_register", 16'h00FF, {8'h00, working_register});
        chk_val("flags", 16'h0006, {12'h000, flags});
        chk_bit("file_wr_en", 1'b0, file_wr_en);
        $display("call test done");
        rst_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
        check_reset();
        chk_val("upper_pc_latch", 16'h0000, {8'h00, upper_pc_latch});
        $display("second reset test done");
        print_verdict();
    end
endmodule : cpu_instr_call_to_decrement_file_bench
